// File: hdl/erx_regs.svh
// Register offsets, field positions and reset values of the receive event latch block.
// Assumes an AXI4-Lite slave with 32-bit data; offsets are word indices, byte address is 4x.
`ifndef ERX_REGS_SVH
`define ERX_REGS_SVH

// ****************************************
// Word indices
// ****************************************
`define ERX_IDX_COUNT_STATUS 10'h126
`define ERX_IDX_LATCH_A 10'h128
`define ERX_IDX_EVENT_LATCHES 10'h12a
`define ERX_IDX_IRQ_ENABLE_A 10'h12c
`define ERX_IDX_IRQ_ENABLE_B 10'h12e

// ****************************************
// Field positions, event latches and enable b
// ****************************************
`define ERX_BIT_REMOTE_ERR 10
`define ERX_BIT_PARITY_ERR 9
`define ERX_BIT_FRAMING_ERR 8
`define ERX_BIT_REMOTE_CNT 2
`define ERX_BIT_PARITY_CNT 1
`define ERX_BIT_FRAMING_CNT 0

// ****************************************
// Field positions, enable a
// ****************************************
`define ERX_BIT_TIMING_SRC 13
`define ERX_BIT_PAYLOAD_UNSTABLE 12
`define ERX_BIT_PAYLOAD_MISMATCH 11
`define ERX_BIT_PAYLOAD_CHANGE 10
`define ERX_BIT_UNFRAMED_ONES 8
`define ERX_BIT_GC_BYTE 7
`define ERX_BIT_NR_BYTE 6
`define ERX_BIT_ALIGN_CHANGE 5
`define ERX_BIT_FRAME_LOSS 4
`define ERX_BIT_REMOTE_DEFECT 3
`define ERX_BIT_ALARM_SIGNAL 2
`define ERX_BIT_OUT_OF_ALIGN 1
`define ERX_BIT_SIGNAL_LOSS 0

// ****************************************
// Implemented bit masks and reset values
// ****************************************
`define ERX_MASK_B 16'h0707
`define ERX_MASK_A 16'h3dff
`define ERX_RST_EVENT_LATCHES 16'h0000
`define ERX_RST_IRQ_ENABLE 16'h0000

// ****************************************
// Bus responses
// ****************************************
`define ERX_RESP_OKAY 2'h0
`define ERX_RESP_SLVERR 2'h2

`endif

// File: hdl/erx_pkg.sv
// Types of the receive event latch block.
// Assumes the constants header is included by the module that uses these types.
package erx_pkg;

    // ****************************************
    // Whole state of the block
    // ****************************************
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] event_latches;
        logic [15:0] irq_enable_a;
        logic [15:0] irq_enable_b;
        logic [2:0] count_prev;
        logic port_irq;
    } erx_state_t;

endpackage

// File: hdl/erx_event_latch.sv
// Receive event latches and interrupt enables of one framed-format receive port.
// Assumes synchronous event pulses and count flags on aclk, and the first latch set
// kept by the framer outside and presented here as a level vector.
//
// Overview of operation
// RULE_01: Remote error indication pulse sets event latch bit 10.
// RULE_02: Parity error pulse sets event latch bit 9.
// RULE_03: Framing error pulse sets event latch bit 8.
// RULE_04: Remote error count flag rising sets bit 2, no other change does.
// RULE_05: Parity error count flag rising sets bit 1.
// RULE_06: Framing error count flag rising sets bit 0.
// RULE_07: Enable lets a set flag interrupt only while this port's global bit is set.
// RULE_08: Enable a bit 13 gates timing source change flag.
// RULE_09: Enable a bit 12 gates payload unstable flag.
// RULE_10: Enable a bit 11 gates payload mismatch flag.
// RULE_11: Enable a bit 10 gates payload change flag.
// RULE_12: Enable a bit 8 gates unframed all ones change flag.
// RULE_13: Enable a bits 7 and 6 gate GC and NR byte change flags.
// RULE_14: Enable a bit 5 gates frame alignment change flag.
// RULE_15: Enable a bit 4 gates loss of frame change flag.
// RULE_16: Enable a bit 3 gates remote defect change flag.
// RULE_17: Enable a bit 2 gates alarm signal change flag.
// RULE_18: Enable a bit 1 gates out of frame change flag.
// RULE_19: Enable a bit 0 gates loss of signal change flag.
// RULE_20: Enable b bit 10 gates remote error flag.
// RULE_21: Enable b bit 9 gates parity error flag.
// RULE_22: Enable b bit 8 gates framing error flag.
// RULE_23: Enable b bit 2 gates remote error count flag.
// RULE_24: Enable b bit 1 gates parity error count flag.
// RULE_25: Enable b bit 0 gates framing error count flag.
// RULE_26: Flags stay set until written one; a same-cycle event keeps them set.
// RULE_27: Interrupt is OR of enabled set flags, drops once all cleared or disabled.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "erx_regs.svh"

module erx_event_latch #(
    parameter int PORT_INDEX = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic remote_err_event,
    input wire logic parity_err_event,
    input wire logic framing_err_event,
    input wire logic remote_err_count_nonzero,
    input wire logic parity_err_count_nonzero,
    input wire logic framing_err_count_nonzero,
    input wire logic [15:0] rx_status_latch_a,
    input wire logic [4:1] global_port_irq_enable_field,
    output logic port_irq
);

    // ****************************************
    // State and next state
    // ****************************************
    erx_pkg::erx_state_t state_reg;
    erx_pkg::erx_state_t state_next;

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [15:0] wr_mask;
    logic [15:0] set_b;
    logic [15:0] gated_a;
    logic [15:0] gated_b;
    logic port_on;
    logic wr_hit_latches;
    logic wr_hit_enable_a;
    logic wr_hit_enable_b;
    logic wr_hit_count;
    logic wr_hit_latch_a;
    logic rd_hit_latches;
    logic rd_hit_enable_a;
    logic rd_hit_enable_b;
    logic rd_hit_count;
    logic rd_hit_latch_a;
    logic [2:0] count_now;
    logic [2:0] count_rise;

    // Write channels stall while a response waits, so one write is in flight
    assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
    assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign port_irq = state_reg.port_irq;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign have_aw = state_reg.aw_held || aw_take;
    assign have_w = state_reg.w_held || w_take;
    assign do_write = have_aw && have_w;
    assign wr_addr = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
    assign wr_data = state_reg.w_held ? state_reg.w_data : s_axi_wdata;
    assign wr_strb = state_reg.w_held ? state_reg.w_strb : s_axi_wstrb;
    assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // ****************************************
    // Count flag edges
    // ****************************************
    // A flag already high when reset lifts counts as a rise
    assign count_now = {remote_err_count_nonzero, parity_err_count_nonzero,
        framing_err_count_nonzero};
    assign count_rise = count_now & ~state_reg.count_prev;

    // ****************************************
    // Event sources
    // ****************************************
    always_comb
    begin
        set_b = 16'h0000;
        set_b[`ERX_BIT_REMOTE_ERR] = remote_err_event; // [RULE_01]
        set_b[`ERX_BIT_PARITY_ERR] = parity_err_event; // [RULE_02]
        set_b[`ERX_BIT_FRAMING_ERR] = framing_err_event; // [RULE_03]
        // Rising edge only; a count that stays nonzero must not re-set a cleared flag
        set_b[`ERX_BIT_REMOTE_CNT] = count_rise[2]; // [RULE_04]
        set_b[`ERX_BIT_PARITY_CNT] = count_rise[1]; // [RULE_05]
        set_b[`ERX_BIT_FRAMING_CNT] = count_rise[0]; // [RULE_06]
    end

    // ****************************************
    // Interrupt gating
    // ****************************************
    always_comb
    begin
        gated_a = 16'h0000;
        gated_b = 16'h0000;
        gated_a[`ERX_BIT_TIMING_SRC] = rx_status_latch_a[`ERX_BIT_TIMING_SRC]
            && state_reg.irq_enable_a[`ERX_BIT_TIMING_SRC]; // [RULE_08]
        gated_a[`ERX_BIT_PAYLOAD_UNSTABLE] = rx_status_latch_a[`ERX_BIT_PAYLOAD_UNSTABLE]
            && state_reg.irq_enable_a[`ERX_BIT_PAYLOAD_UNSTABLE]; // [RULE_09]
        gated_a[`ERX_BIT_PAYLOAD_MISMATCH] = rx_status_latch_a[`ERX_BIT_PAYLOAD_MISMATCH]
            && state_reg.irq_enable_a[`ERX_BIT_PAYLOAD_MISMATCH]; // [RULE_10]
        gated_a[`ERX_BIT_PAYLOAD_CHANGE] = rx_status_latch_a[`ERX_BIT_PAYLOAD_CHANGE]
            && state_reg.irq_enable_a[`ERX_BIT_PAYLOAD_CHANGE]; // [RULE_11]
        gated_a[`ERX_BIT_UNFRAMED_ONES] = rx_status_latch_a[`ERX_BIT_UNFRAMED_ONES]
            && state_reg.irq_enable_a[`ERX_BIT_UNFRAMED_ONES]; // [RULE_12]
        gated_a[`ERX_BIT_GC_BYTE] = rx_status_latch_a[`ERX_BIT_GC_BYTE]
            && state_reg.irq_enable_a[`ERX_BIT_GC_BYTE]; // [RULE_13]
        gated_a[`ERX_BIT_NR_BYTE] = rx_status_latch_a[`ERX_BIT_NR_BYTE]
            && state_reg.irq_enable_a[`ERX_BIT_NR_BYTE]; // [RULE_13]
        gated_a[`ERX_BIT_ALIGN_CHANGE] = rx_status_latch_a[`ERX_BIT_ALIGN_CHANGE]
            && state_reg.irq_enable_a[`ERX_BIT_ALIGN_CHANGE]; // [RULE_14]
        gated_a[`ERX_BIT_FRAME_LOSS] = rx_status_latch_a[`ERX_BIT_FRAME_LOSS]
            && state_reg.irq_enable_a[`ERX_BIT_FRAME_LOSS]; // [RULE_15]
        gated_a[`ERX_BIT_REMOTE_DEFECT] = rx_status_latch_a[`ERX_BIT_REMOTE_DEFECT]
            && state_reg.irq_enable_a[`ERX_BIT_REMOTE_DEFECT]; // [RULE_16]
        gated_a[`ERX_BIT_ALARM_SIGNAL] = rx_status_latch_a[`ERX_BIT_ALARM_SIGNAL]
            && state_reg.irq_enable_a[`ERX_BIT_ALARM_SIGNAL]; // [RULE_17]
        gated_a[`ERX_BIT_OUT_OF_ALIGN] = rx_status_latch_a[`ERX_BIT_OUT_OF_ALIGN]
            && state_reg.irq_enable_a[`ERX_BIT_OUT_OF_ALIGN]; // [RULE_18]
        gated_a[`ERX_BIT_SIGNAL_LOSS] = rx_status_latch_a[`ERX_BIT_SIGNAL_LOSS]
            && state_reg.irq_enable_a[`ERX_BIT_SIGNAL_LOSS]; // [RULE_19]
        gated_b[`ERX_BIT_REMOTE_ERR] = state_reg.event_latches[`ERX_BIT_REMOTE_ERR]
            && state_reg.irq_enable_b[`ERX_BIT_REMOTE_ERR]; // [RULE_20]
        gated_b[`ERX_BIT_PARITY_ERR] = state_reg.event_latches[`ERX_BIT_PARITY_ERR]
            && state_reg.irq_enable_b[`ERX_BIT_PARITY_ERR]; // [RULE_21]
        gated_b[`ERX_BIT_FRAMING_ERR] = state_reg.event_latches[`ERX_BIT_FRAMING_ERR]
            && state_reg.irq_enable_b[`ERX_BIT_FRAMING_ERR]; // [RULE_22]
        gated_b[`ERX_BIT_REMOTE_CNT] = state_reg.event_latches[`ERX_BIT_REMOTE_CNT]
            && state_reg.irq_enable_b[`ERX_BIT_REMOTE_CNT]; // [RULE_23]
        gated_b[`ERX_BIT_PARITY_CNT] = state_reg.event_latches[`ERX_BIT_PARITY_CNT]
            && state_reg.irq_enable_b[`ERX_BIT_PARITY_CNT]; // [RULE_24]
        gated_b[`ERX_BIT_FRAMING_CNT] = state_reg.event_latches[`ERX_BIT_FRAMING_CNT]
            && state_reg.irq_enable_b[`ERX_BIT_FRAMING_CNT]; // [RULE_25]
    end

    assign port_on = global_port_irq_enable_field[PORT_INDEX + 1]; // [RULE_07]

    // ****************************************
    // Address decode
    // ****************************************
    // Word index only; the two low address bits are ignored, not refused
    always_comb
    begin
        wr_hit_latches = 1'b0;
        wr_hit_enable_a = 1'b0;
        wr_hit_enable_b = 1'b0;
        wr_hit_count = 1'b0;
        wr_hit_latch_a = 1'b0;
        if (wr_addr[11:2] == `ERX_IDX_EVENT_LATCHES)
        begin
            wr_hit_latches = 1'b1;
        end
        else if (wr_addr[11:2] == `ERX_IDX_IRQ_ENABLE_A)
        begin
            wr_hit_enable_a = 1'b1;
        end
        else if (wr_addr[11:2] == `ERX_IDX_IRQ_ENABLE_B)
        begin
            wr_hit_enable_b = 1'b1;
        end
        else if (wr_addr[11:2] == `ERX_IDX_COUNT_STATUS)
        begin
            wr_hit_count = 1'b1;
        end
        else if (wr_addr[11:2] == `ERX_IDX_LATCH_A)
        begin
            wr_hit_latch_a = 1'b1;
        end
    end

    // The two mirrors are read only; a write to them is answered and dropped
    always_comb
    begin
        rd_hit_latches = 1'b0;
        rd_hit_enable_a = 1'b0;
        rd_hit_enable_b = 1'b0;
        rd_hit_count = 1'b0;
        rd_hit_latch_a = 1'b0;
        if (s_axi_araddr[11:2] == `ERX_IDX_EVENT_LATCHES)
        begin
            rd_hit_latches = 1'b1;
        end
        else if (s_axi_araddr[11:2] == `ERX_IDX_IRQ_ENABLE_A)
        begin
            rd_hit_enable_a = 1'b1;
        end
        else if (s_axi_araddr[11:2] == `ERX_IDX_IRQ_ENABLE_B)
        begin
            rd_hit_enable_b = 1'b1;
        end
        else if (s_axi_araddr[11:2] == `ERX_IDX_COUNT_STATUS)
        begin
            rd_hit_count = 1'b1;
        end
        else if (s_axi_araddr[11:2] == `ERX_IDX_LATCH_A)
        begin
            rd_hit_latch_a = 1'b1;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.count_prev = count_now;
        // Registered output costs one cycle but keeps the pin glitch free
        state_next.port_irq = port_on && ((|gated_a) || (|gated_b)); // [RULE_07] [RULE_27]

        if (aw_take)
        begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready)
        begin
            state_next.bvalid = 1'b0;
        end

        // Events set here; the clear below ORs set_b in again, so a same-cycle clear cannot drop them
        state_next.event_latches = state_reg.event_latches | set_b; // [RULE_26]

        if (do_write)
        begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = `ERX_RESP_OKAY;
            if (wr_hit_latches)
            begin
                state_next.event_latches = (state_reg.event_latches
                    & ~(wr_data[15:0] & wr_mask)) | set_b; // [RULE_26]
            end
            else if (wr_hit_enable_a)
            begin
                state_next.irq_enable_a = ((state_reg.irq_enable_a & ~wr_mask)
                    | (wr_data[15:0] & wr_mask)) & `ERX_MASK_A;
            end
            else if (wr_hit_enable_b)
            begin
                state_next.irq_enable_b = ((state_reg.irq_enable_b & ~wr_mask)
                    | (wr_data[15:0] & wr_mask)) & `ERX_MASK_B;
            end
            else if (wr_hit_count || wr_hit_latch_a)
            begin
                state_next.bresp = `ERX_RESP_OKAY;
            end
            else
            begin
                state_next.bresp = `ERX_RESP_SLVERR;
            end
        end

        if (state_reg.rvalid && s_axi_rready)
        begin
            state_next.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = `ERX_RESP_OKAY;
            state_next.rdata = 32'h0000_0000;
            if (rd_hit_latches)
            begin
                state_next.rdata[15:0] = state_reg.event_latches;
            end
            else if (rd_hit_enable_a)
            begin
                state_next.rdata[15:0] = state_reg.irq_enable_a;
            end
            else if (rd_hit_enable_b)
            begin
                state_next.rdata[15:0] = state_reg.irq_enable_b;
            end
            else if (rd_hit_count)
            begin
                state_next.rdata[2:0] = count_now;
            end
            else if (rd_hit_latch_a)
            begin
                state_next.rdata[15:0] = rx_status_latch_a & `ERX_MASK_A;
            end
            else
            begin
                state_next.rresp = `ERX_RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= '0;
            state_reg.event_latches <= `ERX_RST_EVENT_LATCHES;
            state_reg.irq_enable_a <= `ERX_RST_IRQ_ENABLE;
            state_reg.irq_enable_b <= `ERX_RST_IRQ_ENABLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule

// File: tb/erx_event_latch_props.sv
// Port checks of the receive event latch block.
// Assumes it is bound to erx_event_latch and sees only that module's ports.
`timescale 1ns/1ps
module erx_event_latch_props #(
    parameter int PORT_INDEX = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [4:1] global_port_irq_enable_field,
    input wire logic port_irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("Write answer not one cycle after");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer not one cycle after");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken while response pending");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken while data pending");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response repeated");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("Read data repeated");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("Upper read half not zero");
    a_irq_port_off: assert property (
        !global_port_irq_enable_field[PORT_INDEX + 1] |=> !port_irq)
        else $error("Interrupt while port disabled");
    a_reset_quiet: assert property ($rose(aresetn) |-> !port_irq && !s_axi_bvalid
        && !s_axi_rvalid) else $error("Outputs busy after reset");
endmodule

bind erx_event_latch erx_event_latch_props #(.PORT_INDEX(PORT_INDEX)) erx_event_latch_props_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .port_irq(port_irq),
    .global_port_irq_enable_field(global_port_irq_enable_field));

// File: tb/tb_erx_event_latch.sv
// Self-checking bench of the receive event latch block.
// Assumes the register header and one clock; port 2 is used to exercise the global field.
`timescale 1ns/1ps
`include "erx_regs.svh"
module tb_erx_event_latch;
    localparam int PORT = 2;
    localparam logic [11:0] A_LAT = {`ERX_IDX_EVENT_LATCHES, 2'h0};
    localparam logic [11:0] A_ENA = {`ERX_IDX_IRQ_ENABLE_A, 2'h0};
    localparam logic [11:0] A_ENB = {`ERX_IDX_IRQ_ENABLE_B, 2'h0};
    localparam logic [11:0] A_CNT = {`ERX_IDX_COUNT_STATUS, 2'h0};
    localparam logic [11:0] A_LTA = {`ERX_IDX_LATCH_A, 2'h0};
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
    logic rready = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [5:0] src = '0;
    logic [15:0] lat_a = '0;
    logic [4:1] gport = '0;
    logic awready, wready, bvalid, arready, rvalid, port_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int errors = 0;
    int checks_done = 0;

    erx_event_latch #(.PORT_INDEX(PORT)) erx_event_latch_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .remote_err_event(src[5]), .parity_err_event(src[4]), .framing_err_event(src[3]),
        .remote_err_count_nonzero(src[2]), .parity_err_count_nonzero(src[1]),
        .framing_err_count_nonzero(src[0]), .rx_status_latch_a(lat_a),
        .global_port_irq_enable_field(gport), .port_irq(port_irq));

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic no_answer;
        errors++;
        $display("CHECK FAILED t=%0t bus gave no answer", $time);
        finish_test();
    endtask

    // Ready is sampled half a cycle early; it only moves on rising edges
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 20; n++)
        begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
            if (b_ok) break;
        end
        bready <= 1'h0;
        if (n == 20) no_answer();
        check(32'(r), 32'(er));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 20; n++)
        begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'h0;
            if (r_ok) break;
        end
        rready <= 1'h0;
        if (n == 20) no_answer();
        check(d, ed);
        check(32'(r), 32'(er));
    endtask

    function automatic logic [15:0] lb(input int k);
        return (k > 2) ? (16'h0001 << (k + 5)) : (16'h0001 << k);
    endfunction

    task automatic pulse(input logic [5:0] v);
        @(posedge aclk);
        src <= v;
        @(posedge aclk);
        src <= '0;
    endtask

    // Looks mid-cycle, then returns on a rising edge for the next stimulus
    task automatic irq_is(input logic e);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check(32'(port_irq), 32'(e));
        @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs;
        rd(A_ENA, 32'h0, 2'h0);
        rd(A_ENB, 32'h0, 2'h0);
        rd(A_LAT, 32'h0, 2'h0);
        wr(A_ENA, 16'hffff, 2'h0);
        rd(A_ENA, {16'h0000, `ERX_MASK_A}, 2'h0);
        wr(A_ENB, 16'hffff, 2'h0);
        rd(A_ENB, {16'h0000, `ERX_MASK_B}, 2'h0);
        wr(A_LAT, 16'hffff, 2'h0);
        rd(A_LAT, 32'h0, 2'h0);
        wr(12'hffc, 16'h1234, `ERX_RESP_SLVERR);
        rd(12'hffc, 32'h0, `ERX_RESP_SLVERR);
        wr(A_CNT, 16'hffff, 2'h0);
        rd(A_CNT, 32'h0, 2'h0);
        wr(A_LTA, 16'hffff, 2'h0);
        rd(A_LTA, 32'h0, 2'h0);
        wr(A_ENA, 16'h0000, 2'h0);
        wr(A_ENB, 16'h0000, 2'h0);
        $display("test regs done");
    endtask

    task automatic test_events;
        for (int k = 0; k < 6; k++)
        begin
            pulse(6'h01 << k);
            rd(A_LAT, {16'h0000, lb(k)}, 2'h0);
            wr(A_LAT, lb(k), 2'h0);
            rd(A_LAT, 32'h0, 2'h0);
        end
        @(posedge aclk);
        src <= 6'h22;
        wr(A_LAT, 16'h0402, 2'h0);
        rd(A_LAT, 32'h0400, 2'h0);
        rd(A_CNT, 32'h0002, 2'h0);
        src <= 6'h02;
        wr(A_LAT, 16'h0402, 2'h0);
        rd(A_LAT, 32'h0, 2'h0);
        src <= 6'h00;
        rd(A_LAT, 32'h0, 2'h0);
        $display("test events done");
    endtask

    task automatic test_irq_b;
        @(posedge aclk);
        gport <= 4'hf;
        for (int k = 0; k < 6; k++)
        begin
            wr(A_ENB, lb(k), 2'h0);
            pulse(6'h3f & ~(6'h01 << k));
            irq_is(1'h0);
            pulse(6'h01 << k);
            irq_is(1'h1);
            gport[PORT + 1] <= 1'h0;
            irq_is(1'h0);
            gport[PORT + 1] <= 1'h1;
            irq_is(1'h1);
            wr(A_LAT, 16'h0707, 2'h0);
            irq_is(1'h0);
        end
        wr(A_ENB, 16'h0000, 2'h0);
        $display("test irq b done");
    endtask

    task automatic test_irq_a;
        for (int i = 0; i < 16; i++)
        begin
            if (`ERX_MASK_A & (16'h0001 << i))
            begin
                wr(A_ENA, 16'h0001 << i, 2'h0);
                lat_a <= ~(16'h0001 << i);
                irq_is(1'h0);
                lat_a <= 16'h0001 << i;
                irq_is(1'h1);
                rd(A_LTA, {16'h0000, 16'h0001 << i}, 2'h0);
                lat_a <= 16'h0000;
                irq_is(1'h0);
            end
        end
        $display("test irq a done");
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        test_regs();
        test_events();
        test_irq_b();
        test_irq_a();
        finish_test();
    end
endmodule
